// ===== inc/drf_pkg.sv
package drf_pkg;

	// Bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] CONFIG_OFFSET = 4'h0;
	localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 4'h4;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h8;
	localparam logic [ADDR_W-1:0] SWITCH_COUNT_OFFSET = 4'hC;

	// Reference / feedback configuration register
	localparam int REF_MODE_LSB = 6;
	localparam int REF_SEL_LSB = 4;
	localparam int FB_SEL_LSB = 2;
	localparam int REVERTIVE_BIT = 1;
	localparam int HITLESS_BIT = 0;
	localparam logic [7:0] CONFIG_RESET = 8'h04;

	// Reference selection modes
	localparam logic [1:0] REF_MODE_REGISTER = 2'h0;
	localparam logic [1:0] REF_MODE_PINS = 2'h1;
	localparam logic [1:0] REF_MODE_AUTO = 2'h2;
	localparam logic [1:0] REF_MODE_AUTO_ALT = 2'h3;

	// Feedback sources
	localparam logic [1:0] FB_SEL_EXTERNAL = 2'h0;
	localparam logic [1:0] FB_SEL_INTERNAL = 2'h1;

	// Control register
	localparam int DIV_OFF_BIT = 0;
	localparam int DEC_BW_LSB = 4;
	localparam int DEC_BW_W = 3;
	localparam logic [7:0] CONTROL_RESET = 8'h30;

	// Status register
	localparam int STATUS_ACTIVE_LSB = 0;
	localparam int STATUS_NO_REF_BIT = 2;
	localparam int STATUS_VALID_LSB = 4;

	// Reference inputs
	localparam int NUM_REFS = 4;
	localparam int REF_W = 2;
	localparam int GP_PIN_W = 2;
	localparam int COUNT_W = 8;

	typedef enum {
		BUS_IDLE,
		BUS_ACK
	} drf_bus_state_t;

endpackage

// ===== hw/drf_auto_select.sv
`timescale 1ns/10ps
module drf_auto_select #(
	parameter int NUM_REFS = drf_pkg::NUM_REFS,
	parameter int REF_W = drf_pkg::REF_W
) (
	input wire logic [NUM_REFS-1:0] validRefs,
	input wire logic [REF_W-1:0] currentRef,
	input wire logic revertive,
	output logic [REF_W-1:0] nextRef,
	output logic anyValid
);
	import drf_pkg::*;

	logic [NUM_REFS-1:0] firstValid;
	logic [REF_W-1:0] bestRef;

	// Lowest index wins: index 0 has the highest priority
	genvar i;
	generate
		for (i = 0; i < NUM_REFS; i++) begin : g_first
			if (i == 0) begin : g_top
				assign firstValid[i] = validRefs[0];
			end else begin : g_rest
				assign firstValid[i] = validRefs[i] && !(|validRefs[i-1:0]);
			end
		end
	endgenerate

	assign anyValid = |validRefs;

	always_comb begin
		bestRef = '0;
		for (int k = 0; k < NUM_REFS; k++) begin
			if (firstValid[k]) begin
				bestRef = REF_W'(k);
			end
		end
	end

	always_comb begin
		if (!anyValid) begin
			// Nothing usable: stay put and let the loop ride through
			nextRef = currentRef;
		end else if (!validRefs[currentRef]) begin
			nextRef = bestRef;
		end else if (revertive && (bestRef < currentRef)) begin
			nextRef = bestRef;
		end else begin
			nextRef = currentRef;
		end
	end

endmodule

// ===== hw/drf_ref_fb_select.sv
`timescale 1ns/10ps
module drf_ref_fb_select (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [drf_pkg::ADDR_W-1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [drf_pkg::DATA_W-1:0] avsWriteData,
	input wire logic [drf_pkg::BE_W-1:0] avsByteEnable,
	output logic [drf_pkg::DATA_W-1:0] avsReadData,
	output logic avsWaitRequest,
	input wire logic [drf_pkg::GP_PIN_W-1:0] generalPurposePins,
	input wire logic [drf_pkg::NUM_REFS-1:0] refValid,
	output logic [drf_pkg::REF_W-1:0] activeRef,
	output logic noValidRef,
	output logic feedbackExternal,
	output logic feedbackDividerOff,
	output logic revertiveEnable,
	output logic hitlessEnable,
	output logic [drf_pkg::DEC_BW_W-1:0] switchDecimatorBandwidth,
	output logic hitlessSwitchPulse
);
	import drf_pkg::*;

	drf_bus_state_t busState_reg;
	logic avsWaitRequest_reg;
	logic [DATA_W-1:0] avsReadData_reg;
	logic [7:0] refFbConfig_reg;
	logic [7:0] refFbControl_reg;
	logic [COUNT_W-1:0] switchCount_reg;
	logic [GP_PIN_W-1:0] gpMeta_reg;
	logic [GP_PIN_W-1:0] gpSync_reg;
	logic [GP_PIN_W-1:0] gpPrev_reg;
	logic [NUM_REFS-1:0] validMeta_reg;
	logic [NUM_REFS-1:0] validSync_reg;
	logic [REF_W-1:0] activeRef_reg;
	logic [REF_W-1:0] activeRef_next;
	logic noValidRef_reg;
	logic feedbackExternal_reg;
	logic feedbackDividerOff_reg;
	logic revertiveEnable_reg;
	logic hitlessEnable_reg;
	logic [DEC_BW_W-1:0] switchDecimatorBandwidth_reg;
	logic hitlessSwitchPulse_reg;
	logic [DATA_W-1:0] readMux;
	logic busCommit;
	logic lowLaneWrite;
	logic [1:0] refMode;
	logic [1:0] feedbackSourceChoice;
	logic autoMode;
	logic [REF_W-1:0] autoRef;
	logic anyValid;
	logic refChange;

	assign refMode = refFbConfig_reg[REF_MODE_LSB+:2];
	assign feedbackSourceChoice = refFbConfig_reg[FB_SEL_LSB+:2];
	assign autoMode = (refMode == REF_MODE_AUTO) || (refMode == REF_MODE_AUTO_ALT);

	// Pins and monitor flags come from other clock domains
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gpMeta_reg <= '0;
			gpSync_reg <= '0;
			gpPrev_reg <= '0;
			validMeta_reg <= '0;
			validSync_reg <= '0;
		end else begin
			gpMeta_reg <= generalPurposePins;
			gpSync_reg <= gpMeta_reg;
			gpPrev_reg <= gpSync_reg;
			validMeta_reg <= refValid;
			validSync_reg <= validMeta_reg;
		end
	end

	// Bus handshake: one wait cycle, then a single-cycle acknowledge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busState_reg <= BUS_IDLE;
		end else begin
			case (busState_reg)
				BUS_IDLE: begin
					if (avsRead || avsWrite) begin
						busState_reg <= BUS_ACK;
					end
				end
				BUS_ACK: begin
					busState_reg <= BUS_IDLE;
				end
				default: begin
					busState_reg <= BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			avsWaitRequest_reg <= 1'b1;
		end else begin
			avsWaitRequest_reg <= !((busState_reg == BUS_IDLE) && (avsRead || avsWrite));
		end
	end

	assign busCommit = (busState_reg == BUS_ACK);
	assign lowLaneWrite = busCommit && avsWrite && avsByteEnable[0];

	always_comb begin
		readMux = '0;
		if (avsAddress == CONFIG_OFFSET) begin
			readMux[7:0] = refFbConfig_reg;
		end else if (avsAddress == CONTROL_OFFSET) begin
			readMux[7:0] = refFbControl_reg;
		end else if (avsAddress == STATUS_OFFSET) begin
			readMux[STATUS_ACTIVE_LSB+:REF_W] = activeRef_reg;
			readMux[STATUS_NO_REF_BIT] = noValidRef_reg;
			readMux[STATUS_VALID_LSB+:NUM_REFS] = validSync_reg;
		end else if (avsAddress == SWITCH_COUNT_OFFSET) begin
			readMux[COUNT_W-1:0] = switchCount_reg;
		end else begin
			readMux = '0;
		end
	end

	// Read data is held until the next read request so it is stable at the acknowledge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			avsReadData_reg <= '0;
		end else if ((busState_reg == BUS_IDLE) && avsRead) begin
			avsReadData_reg <= readMux;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			refFbConfig_reg <= CONFIG_RESET;
		end else if (lowLaneWrite && (avsAddress == CONFIG_OFFSET)) begin
			refFbConfig_reg <= avsWriteData[7:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			refFbControl_reg <= CONTROL_RESET;
		end else if (lowLaneWrite && (avsAddress == CONTROL_OFFSET)) begin
			refFbControl_reg <= avsWriteData[7:0];
		end
	end

	drf_auto_select #(
		.NUM_REFS(NUM_REFS),
		.REF_W(REF_W)
	) u_auto_select (
		.validRefs(validSync_reg),
		.currentRef(activeRef_reg),
		.revertive(refFbConfig_reg[REVERTIVE_BIT]),
		.nextRef(autoRef),
		.anyValid(anyValid)
	);

	always_comb begin
		if (refMode == REF_MODE_REGISTER) begin
			activeRef_next = refFbConfig_reg[REF_SEL_LSB+:REF_W];
		end else if (refMode == REF_MODE_PINS) begin
			// Pin bits resolve one by one; an index is used only once two samples agree, so a one-cycle skew passes no third index
			activeRef_next = (gpSync_reg == gpPrev_reg) ? gpSync_reg : activeRef_reg;
		end else begin
			activeRef_next = autoRef;
		end
	end

	assign refChange = (activeRef_next != activeRef_reg);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			activeRef_reg <= '0;
			noValidRef_reg <= 1'b1;
		end else begin
			activeRef_reg <= activeRef_next;
			noValidRef_reg <= !anyValid;
		end
	end

	// Saturating count of reference changes; a write clears it, a change in the same cycle is counted after the clear, leaving 1
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			switchCount_reg <= '0;
		end else if (refChange) begin
			if (lowLaneWrite && (avsAddress == SWITCH_COUNT_OFFSET)) begin
				switchCount_reg <= COUNT_W'(1);
			end else if (switchCount_reg != '1) begin
				switchCount_reg <= switchCount_reg + COUNT_W'(1);
			end
		end else if (lowLaneWrite && (avsAddress == SWITCH_COUNT_OFFSET)) begin
			switchCount_reg <= '0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			feedbackExternal_reg <= 1'b0;
			feedbackDividerOff_reg <= 1'b0;
		end else begin
			feedbackExternal_reg <= (feedbackSourceChoice == FB_SEL_EXTERNAL);
			// Internal feedback needs its divider, so the off request is masked
			feedbackDividerOff_reg <= (feedbackSourceChoice == FB_SEL_EXTERNAL)
				&& refFbControl_reg[DIV_OFF_BIT];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			revertiveEnable_reg <= 1'b0;
			hitlessEnable_reg <= 1'b0;
			switchDecimatorBandwidth_reg <= '0;
			hitlessSwitchPulse_reg <= 1'b0;
		end else begin
			revertiveEnable_reg <= refFbConfig_reg[REVERTIVE_BIT];
			hitlessEnable_reg <= refFbConfig_reg[HITLESS_BIT];
			switchDecimatorBandwidth_reg <= refFbConfig_reg[HITLESS_BIT]
				? refFbControl_reg[DEC_BW_LSB+:DEC_BW_W] : '0;
			hitlessSwitchPulse_reg <= refFbConfig_reg[HITLESS_BIT] && refChange;
		end
	end

	assign avsReadData = avsReadData_reg;
	assign avsWaitRequest = avsWaitRequest_reg;
	assign activeRef = activeRef_reg;
	assign noValidRef = noValidRef_reg;
	assign feedbackExternal = feedbackExternal_reg;
	assign feedbackDividerOff = feedbackDividerOff_reg;
	assign revertiveEnable = revertiveEnable_reg;
	assign hitlessEnable = hitlessEnable_reg;
	assign switchDecimatorBandwidth = switchDecimatorBandwidth_reg;
	assign hitlessSwitchPulse = hitlessSwitchPulse_reg;

	// Checks
	logic [NUM_REFS-1:0] validPast_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			validPast_reg <= '0;
		end else begin
			validPast_reg <= validSync_reg;
		end
	end

	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence cfgManualWrite;
		lowLaneWrite && (avsAddress == CONFIG_OFFSET)
			&& (avsWriteData[REF_MODE_LSB+:2] == REF_MODE_REGISTER);
	endsequence

	sequence refFollows;
		##2 activeRef == $past(avsWriteData[REF_SEL_LSB+:REF_W], 2);
	endsequence

	modeRegister_a: assert property (
		(refMode == REF_MODE_REGISTER) |=> activeRef == $past(refFbConfig_reg[REF_SEL_LSB+:REF_W]))
		else $error("register mode did not follow the manual field");

	modePins_a: assert property (
		(refMode == REF_MODE_PINS) && $stable(gpSync_reg) |=> activeRef == $past(gpSync_reg))
		else $error("pin mode did not follow the synchronised pins");

	pinsSettle_a: assert property (
		(refMode == REF_MODE_PINS) && !$stable(gpSync_reg) |=> $stable(activeRef))
		else $error("pin mode followed an unsettled pin index");

	manualWrite_a: assert property (
		cfgManualWrite |-> refFollows)
		else $error("written manual reference not applied two edges later");

	feedbackSource_a: assert property (
		$past(feedbackSourceChoice == FB_SEL_INTERNAL) |-> !feedbackExternal)
		else $error("internal feedback reported as external");

	dividerOff_a: assert property (
		feedbackDividerOff |-> $past(feedbackSourceChoice) == FB_SEL_EXTERNAL
			&& $past(refFbControl_reg[DIV_OFF_BIT]))
		else $error("feedback divider off without external feedback");

	nonRevertHold_a: assert property (
		autoMode && !refFbConfig_reg[REVERTIVE_BIT] && validSync_reg[activeRef_reg] |=> $stable(activeRef))
		else $error("non-revertive mode left a valid reference");

	revertBack_a: assert property (
		autoMode && refFbConfig_reg[REVERTIVE_BIT] && validSync_reg[0] |=> activeRef == '0)
		else $error("revertive mode did not return to the top reference");

	hitlessSwitch_a: assert property (
		hitlessSwitchPulse |-> $past(refFbConfig_reg[HITLESS_BIT]) && (activeRef != $past(activeRef)))
		else $error("hitless pulse without an enabled switch");

	hitlessOff_a: assert property (
		!refFbConfig_reg[HITLESS_BIT] |=> switchDecimatorBandwidth == '0)
		else $error("decimator bandwidth applied with hitless off");

	autoValid_a: assert property (
		autoMode && anyValid |=> validPast_reg[activeRef])
		else $error("automatic mode chose an invalid reference");

	busAck_a: assert property (
		!avsWaitRequest |=> avsWaitRequest)
		else $error("acknowledge held longer than one cycle");

endmodule

// ===== test/drf_ref_fb_select_tb.sv
`timescale 1ns/10ps
module drf_ref_fb_select_tb;
	import drf_pkg::*;
	typedef struct {
		logic [7:0] cfg;
		logic [7:0] ctl;
		logic [1:0] pins;
		logic [3:0] valid;
		logic [1:0] eRef;
		logic eNone;
	} drf_row_t;
	logic clk = 1'b0;
	logic resetn;
	logic [ADDR_W-1:0] avsAddress;
	logic avsRead;
	logic avsWrite;
	logic [DATA_W-1:0] avsWriteData;
	logic [BE_W-1:0] avsByteEnable;
	logic [DATA_W-1:0] avsReadData;
	logic avsWaitRequest;
	logic [GP_PIN_W-1:0] generalPurposePins;
	logic [NUM_REFS-1:0] refValid;
	logic [REF_W-1:0] activeRef;
	logic noValidRef;
	logic feedbackExternal;
	logic feedbackDividerOff;
	logic revertiveEnable;
	logic hitlessEnable;
	logic [DEC_BW_W-1:0] switchDecimatorBandwidth;
	logic hitlessSwitchPulse;
	int failCount = 0;
	int totalChecks = 0;
	int pulseCount = 0;
	int p0;
	logic [31:0] rd;
	logic ext;
	drf_row_t rows [10];

	drf_ref_fb_select uut (
		.clk(clk),
		.resetn(resetn),
		.avsAddress(avsAddress),
		.avsRead(avsRead),
		.avsWrite(avsWrite),
		.avsWriteData(avsWriteData),
		.avsByteEnable(avsByteEnable),
		.avsReadData(avsReadData),
		.avsWaitRequest(avsWaitRequest),
		.generalPurposePins(generalPurposePins),
		.refValid(refValid),
		.activeRef(activeRef),
		.noValidRef(noValidRef),
		.feedbackExternal(feedbackExternal),
		.feedbackDividerOff(feedbackDividerOff),
		.revertiveEnable(revertiveEnable),
		.hitlessEnable(hitlessEnable),
		.switchDecimatorBandwidth(switchDecimatorBandwidth),
		.hitlessSwitchPulse(hitlessSwitchPulse)
	);

	always #2 clk = ~clk;

	always @(posedge clk) begin
		if (hitlessSwitchPulse === 1'b1) begin
			pulseCount <= pulseCount + 1;
		end
	end

	task automatic endSim();
		$display("checks %0d mismatches %0d", totalChecks, failCount);
		if (failCount == 0 && totalChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		totalChecks++;
		if (got !== exp) begin
			failCount++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Holds the request until waitrequest is sampled low; bounded wait
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk);
		avsAddress <= a;
		avsWrite <= w;
		avsRead <= !w;
		avsWriteData <= {24'hA5A5A5, d};
		avsByteEnable <= be;
		do begin
			@(posedge clk);
			n++;
		end while (avsWaitRequest !== 1'b0 && n < 20);
		rd = avsReadData;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		if (n >= 20) begin
			failCount++;
			$display("BAD waitrequest expected 0 seen %b", avsWaitRequest);
			endSim();
		end
	endtask

	initial begin
		resetn = 1'b0;
		avsAddress = 4'h0;
		avsRead = 1'b0;
		avsWrite = 1'b0;
		avsWriteData = 32'h0;
		avsByteEnable = 4'hF;
		generalPurposePins = 2'h3;
		refValid = 4'hF;
		// Auto rows depend on the reference left by the row before
		rows = '{
			'{8'h00, 8'h01, 2'h3, 4'hF, 2'h0, 1'b0},
			'{8'h11, 8'h51, 2'h3, 4'hF, 2'h1, 1'b0},
			'{8'h26, 8'h01, 2'h3, 4'hF, 2'h2, 1'b0},
			'{8'h34, 8'h51, 2'h3, 4'hF, 2'h3, 1'b0},
			'{8'h40, 8'h00, 2'h2, 4'hF, 2'h2, 1'b0},
			'{8'h71, 8'h61, 2'h1, 4'hF, 2'h1, 1'b0},
			'{8'h84, 8'h00, 2'h1, 4'h8, 2'h3, 1'b0},
			'{8'hC6, 8'h00, 2'h1, 4'hC, 2'h2, 1'b0},
			'{8'hC4, 8'h00, 2'h1, 4'h9, 2'h0, 1'b0},
			'{8'h84, 8'h00, 2'h1, 4'h0, 2'h0, 1'b1}
		};
		repeat (6) @(posedge clk);
		chk("waitrequest in reset", 32'h1, avsWaitRequest);
		chk("activeRef in reset", 32'h0, activeRef);
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		bus(1'b0, CONFIG_OFFSET, 8'h00, 4'hF);
		chk("config reset", 32'h04, rd);
		bus(1'b0, CONTROL_OFFSET, 8'h00, 4'hF);
		chk("control reset", 32'h30, rd);
		chk("feedbackExternal reset", 32'h0, feedbackExternal);
		chk("bandwidth reset", 32'h0, switchDecimatorBandwidth);
		foreach (rows[i]) begin
			@(posedge clk);
			generalPurposePins <= rows[i].pins;
			refValid <= rows[i].valid;
			bus(1'b1, CONFIG_OFFSET, rows[i].cfg, 4'h1);
			bus(1'b1, CONTROL_OFFSET, rows[i].ctl, 4'h1);
			repeat (4) @(posedge clk);
			ext = (rows[i].cfg[3:2] == FB_SEL_EXTERNAL);
			chk("activeRef", rows[i].eRef, activeRef);
			chk("noValidRef", rows[i].eNone, noValidRef);
			chk("feedbackExternal", ext, feedbackExternal);
			chk("feedbackDividerOff", ext & rows[i].ctl[0], feedbackDividerOff);
			chk("revertiveEnable", rows[i].cfg[1], revertiveEnable);
			chk("hitlessEnable", rows[i].cfg[0], hitlessEnable);
			chk("bandwidth", rows[i].cfg[0] ? rows[i].ctl[6:4] : 3'h0, switchDecimatorBandwidth);
		end
		bus(1'b0, STATUS_OFFSET, 8'h00, 4'hF);
		chk("status none valid", 32'h04, rd);
		bus(1'b1, CONFIG_OFFSET, 8'hFF, 4'h0);
		bus(1'b0, CONFIG_OFFSET, 8'h00, 4'hF);
		chk("config after masked write", 32'h84, rd);
		bus(1'b1, 4'h2, 8'hFF, 4'hF);
		bus(1'b0, 4'h2, 8'h00, 4'hF);
		chk("unmapped read", 32'h0, rd);
		@(posedge clk);
		refValid <= 4'hF;
		bus(1'b1, CONFIG_OFFSET, 8'h01, 4'h1);
		repeat (4) @(posedge clk);
		p0 = pulseCount;
		bus(1'b1, CONFIG_OFFSET, 8'h21, 4'h1);
		repeat (4) @(posedge clk);
		chk("hitless pulses", 32'h1, pulseCount - p0);
		chk("activeRef hitless", 32'h2, activeRef);
		bus(1'b1, CONFIG_OFFSET, 8'h00, 4'h1);
		repeat (4) @(posedge clk);
		chk("pulses hitless off", 32'h1, pulseCount - p0);
		chk("activeRef back", 32'h0, activeRef);
		// Ten reference changes since reset: rows 1 to 8 and the two hitless steps
		bus(1'b0, SWITCH_COUNT_OFFSET, 8'h00, 4'hF);
		chk("switch count", 32'h0A, rd);
		bus(1'b1, SWITCH_COUNT_OFFSET, 8'h00, 4'h1);
		bus(1'b0, SWITCH_COUNT_OFFSET, 8'h00, 4'hF);
		chk("switch count cleared", 32'h0, rd);
		// Feedback code 2 counts as internal, so the divider stays on
		bus(1'b1, CONFIG_OFFSET, 8'h39, 4'h1);
		bus(1'b1, CONTROL_OFFSET, 8'h01, 4'h1);
		repeat (4) @(posedge clk);
		chk("feedbackExternal code 2", 32'h0, feedbackExternal);
		chk("feedbackDividerOff code 2", 32'h0, feedbackDividerOff);
		chk("activeRef before reset", 32'h3, activeRef);
		chk("hitlessEnable before reset", 32'h1, hitlessEnable);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		chk("waitrequest mid reset", 32'h1, avsWaitRequest);
		chk("activeRef mid reset", 32'h0, activeRef);
		chk("noValidRef mid reset", 32'h1, noValidRef);
		chk("hitlessEnable mid reset", 32'h0, hitlessEnable);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		bus(1'b0, CONFIG_OFFSET, 8'h00, 4'hF);
		chk("config after mid reset", 32'h04, rd);
		bus(1'b0, CONTROL_OFFSET, 8'h00, 4'hF);
		chk("control after mid reset", 32'h30, rd);
		chk("activeRef after mid reset", 32'h0, activeRef);
		endSim();
	end
endmodule
